//--- rtl/spd_pin_cell.sv
/*
 * one peripheral pin: selects between peripheral drive and the held sleep state.
 * assumes hold and latched bit are registered by the caller.
 */
`timescale 1ns/1ps
module spd_pin_cell (
    input  wire logic hold_i,
    input  wire logic sleep_bit_i,
    input  wire logic periph_out_i,
    input  wire logic periph_dir_i,
    output logic      pin_out_o,
    output logic      pin_oe_n_o
);
    // held: zero bit drives low, one bit releases to input
    always_comb begin
        if (hold_i) begin
            pin_out_o  = 1'b0;
            pin_oe_n_o = sleep_bit_i;
        end else begin
            pin_out_o  = periph_out_i;
            pin_oe_n_o = ~periph_dir_i;
        end
    end
endmodule : spd_pin_cell

//--- rtl/spd_pkg.sv
/*
 * constants for the sleep pin direction block: register map, field layout, reset values.
 * assumes an avalon-mm slave with 32-bit data and byte addressing.
 */
// Function
// - Sleep entry resets all peripherals and the pin controller.
// - Normal direction register clears on hard, soft or sleep reset.
// - Sleep direction register keeps its bits through sleep entry.
// - During sleep all 22 pins follow the sleep direction bits.
// - Bit zero drives pin low as output; bit one makes input.
// - Sleep direction bits are latched before core supply drops.
// - Contents lost without core supply; software rewrites after wake.
// - Sleep entry clears release bit; pins held until set again. The code also frees them on a write of one to the hold bit.
// - Sleep reset sets port 2 transmit and receive polarity to one.
// - Sleep direction register initialised only by hardware reset.
// - Reserved bits ignore writes and read zero.
// - Bits 7..0 display data pins, bit 8 pixel clock.
// - Bit 9 line clock, bit 10 frame clock, bit 11 ac bias.
// - Bit 12 port 1 transmit, bit 13 port 1 receive.
// - Bit 14 port 2 transmit, bit 15 port 2 receive.
// - Bit 16 port 3 transmit, same encoding.
// - Bit 17 port 3 receive; 18..21 port 4 tx, rx, clock, frame.
package spd_pkg;
    localparam int          NPINS           = 22;
    localparam logic [31:0] SLEEP_DIR_ADDR  = 32'h9006000C;
    localparam logic [31:0] NORMAL_DIR_ADDR = 32'h90060000;
    localparam logic [31:0] CTRL_ADDR       = 32'h90060040;
    localparam logic [31:0] STATUS_ADDR     = 32'h90060044;
    localparam logic [21:0] SLEEP_DIR_RST   = 22'h3FFFFF;
    localparam logic [21:0] NORMAL_DIR_RST  = 22'h000000;
    localparam int          CTRL_HOLD_BIT   = 0;
    localparam int          CTRL_REL_BIT    = 1;
    localparam int          CTRL_TXP_BIT    = 2;
    localparam int          CTRL_RXP_BIT    = 3;
    localparam int          ST_SLEEP_BIT    = 0;
    localparam logic [31:0] UNMAPPED_DATA   = 32'h00000000;

    typedef enum logic [1:0] {
        SPD_RUN   = 2'b00,
        SPD_SLEEP = 2'b01,
        SPD_HOLD  = 2'b10
    } spd_mode_e;
endpackage : spd_pkg

//--- rtl/spd_sleep_dir.sv
/*
 * sleep pin direction register bank with pin hold and peripheral resets.
 * assumes avalon-mm master byte addressing, one clock, synchronous pin inputs.
 */
`timescale 1ns/1ps
module spd_sleep_dir (
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        soft_reset_i,
    input  wire logic        sleep_req_i,
    input  wire logic        wake_i,
    input  wire logic [31:0] avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic [21:0] periph_out_i,
    input  wire logic [21:0] periph_dir_i,
    output logic [21:0]      pin_out_o,
    output logic [21:0]      pin_oe_n_o,
    output logic             periph_rst_o,
    output logic [21:0]      normal_pin_direction_o,
    output logic             port2_tx_polarity_o,
    output logic             port2_rx_polarity_o,
    output logic             pin_hold_flag_o
);
    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [21:0]        sleep_dir;
        logic [21:0]        latched;
        logic [21:0]        normal_dir;
        logic               hold;
        logic               release_bit;
        logic               port2_tx_polarity;
        logic               port2_rx_polarity;
        logic               prst;
        logic               ack;
        logic [31:0]        rdata;
        spd_pkg::spd_mode_e mode;
        logic [21:0]        pout;
        logic [21:0]        poen;
    } spd_state_s;

    spd_state_s st_r;
    spd_state_s st_nxt;
    logic [21:0] cell_out;
    logic [21:0] cell_oen;

    // byte-lane merge used by the sleep and normal direction registers
    function automatic logic [31:0] spd_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : spd_merge

    ////////////////////////////////////////////////////////////////////////////
    // pin cells: bit map is the identity, bit n steers pin n
    genvar g;
    generate
        for (g = 0; g < spd_pkg::NPINS; g++) begin : g_pin
            spd_pin_cell u_cell (
                .hold_i       (st_r.hold),
                .sleep_bit_i  (st_r.latched[g]),
                .periph_out_i (periph_out_i[g]),
                .periph_dir_i (periph_dir_i[g]),
                .pin_out_o    (cell_out[g]),
                .pin_oe_n_o   (cell_oen[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic; every access answers in one wait cycle
    always_comb begin
        logic        acc;
        logic [31:0] w;
        acc    = (avs_read_i | avs_write_i) & ~st_r.ack;
        w      = 32'h00000000;
        st_nxt = st_r;
        st_nxt.ack   = acc;
        st_nxt.prst  = 1'b0;
        st_nxt.pout  = cell_out;
        st_nxt.poen  = cell_oen;
        if (acc && avs_read_i) begin
            unique case (avs_address_i)
                spd_pkg::SLEEP_DIR_ADDR:  st_nxt.rdata = {10'h000, st_r.sleep_dir};
                spd_pkg::NORMAL_DIR_ADDR: st_nxt.rdata = {10'h000, st_r.normal_dir};
                spd_pkg::CTRL_ADDR:       st_nxt.rdata = {28'h0000000, st_r.port2_rx_polarity, st_r.port2_tx_polarity,
                                                          st_r.release_bit, st_r.hold};
                spd_pkg::STATUS_ADDR:     st_nxt.rdata = {31'h00000000,
                                              st_r.mode == spd_pkg::SPD_SLEEP};
                default:                  st_nxt.rdata = spd_pkg::UNMAPPED_DATA;
            endcase
        end
        // a write lands on the edge at which the master sees waitrequest low,
        // so the register and the master agree on the edge that takes the value;
        // the ack cycle itself is the only cycle in which a write can land
        if (st_r.ack && avs_write_i) begin
            unique case (avs_address_i)
                spd_pkg::SLEEP_DIR_ADDR: begin
                    w = spd_merge({10'h000, st_r.sleep_dir}, avs_writedata_i,
                                  avs_byteenable_i);
                    st_nxt.sleep_dir = w[21:0];
                end
                spd_pkg::NORMAL_DIR_ADDR: begin
                    w = spd_merge({10'h000, st_r.normal_dir}, avs_writedata_i,
                                  avs_byteenable_i);
                    st_nxt.normal_dir = w[21:0];
                end
                spd_pkg::CTRL_ADDR: begin
                    if (avs_byteenable_i[0]) begin
                        // hold is write-one-to-clear; release bit set releases pins
                        if (avs_writedata_i[spd_pkg::CTRL_HOLD_BIT]) begin
                            st_nxt.hold = 1'b0;
                        end
                        if (avs_writedata_i[spd_pkg::CTRL_REL_BIT]) begin
                            st_nxt.release_bit = 1'b1;
                            st_nxt.hold        = 1'b0;
                        end
                        st_nxt.port2_tx_polarity = avs_writedata_i[spd_pkg::CTRL_TXP_BIT];
                        st_nxt.port2_rx_polarity = avs_writedata_i[spd_pkg::CTRL_RXP_BIT];
                    end
                end
                default: ;
            endcase
        end
        // soft reset clears peripherals but never the sleep direction bits
        if (soft_reset_i) begin
            st_nxt.normal_dir = spd_pkg::NORMAL_DIR_RST;
            st_nxt.prst       = 1'b1;
        end
        unique case (st_r.mode)
            spd_pkg::SPD_RUN: begin
                if (sleep_req_i) begin
                    st_nxt.mode        = spd_pkg::SPD_SLEEP;
                    st_nxt.prst        = 1'b1;
                    st_nxt.normal_dir  = spd_pkg::NORMAL_DIR_RST;
                    st_nxt.port2_tx_polarity         = 1'b1;
                    st_nxt.port2_rx_polarity         = 1'b1;
                    st_nxt.release_bit = 1'b0;
                    st_nxt.hold        = 1'b1;
                    st_nxt.latched     = st_r.sleep_dir;
                end
            end
            spd_pkg::SPD_SLEEP: begin
                st_nxt.prst = 1'b1;
                if (wake_i) begin
                    st_nxt.mode = spd_pkg::SPD_HOLD;
                end
            end
            spd_pkg::SPD_HOLD: begin
                if (!st_nxt.hold) begin
                    st_nxt.mode = spd_pkg::SPD_RUN;
                end
            end
            default: st_nxt.mode = spd_pkg::SPD_RUN;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // only the hardware reset initialises the sleep direction bits
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r.sleep_dir   <= spd_pkg::SLEEP_DIR_RST;
            st_r.latched     <= spd_pkg::SLEEP_DIR_RST;
            st_r.normal_dir  <= spd_pkg::NORMAL_DIR_RST;
            st_r.hold        <= 1'b0;
            st_r.release_bit <= 1'b0;
            st_r.port2_tx_polarity         <= 1'b1;
            st_r.port2_rx_polarity         <= 1'b1;
            st_r.prst        <= 1'b1;
            st_r.ack         <= 1'b0;
            st_r.rdata       <= 32'h00000000;
            st_r.mode        <= spd_pkg::SPD_RUN;
            st_r.pout        <= 22'h000000;
            st_r.poen        <= 22'h3FFFFF;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state flip-flops
    assign avs_readdata_o         = st_r.rdata;
    assign avs_waitrequest_o      = ~st_r.ack;
    assign pin_out_o              = st_r.pout;
    assign pin_oe_n_o             = st_r.poen;
    assign periph_rst_o           = st_r.prst;
    assign normal_pin_direction_o = st_r.normal_dir;
    assign port2_tx_polarity_o    = st_r.port2_tx_polarity;
    assign port2_rx_polarity_o    = st_r.port2_rx_polarity;
    assign pin_hold_flag_o        = st_r.hold;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);


    // sleep entry resets the peripherals in the next cycle
    sleep_rst_a: assert property (
        sleep_req_i && st_r.mode == spd_pkg::SPD_RUN |=> periph_rst_o)
        else $error("no peripheral reset on sleep entry");

    // the peripherals stay in reset for as long as the chip sleeps
    sleep_stay_a: assert property (
        st_r.mode == spd_pkg::SPD_SLEEP |=> periph_rst_o)
        else $error("peripheral reset dropped in sleep");

    // sleep entry clears the normal directions, whatever the bus does
    normal_clr_a: assert property (
        sleep_req_i && st_r.mode == spd_pkg::SPD_RUN
        |=> normal_pin_direction_o == spd_pkg::NORMAL_DIR_RST)
        else $error("normal dir kept");

    // a soft reset clears the normal directions and resets the peripherals
    soft_clr_a: assert property (
        soft_reset_i |=> periph_rst_o && normal_pin_direction_o == spd_pkg::NORMAL_DIR_RST)
        else $error("soft reset missed");

    // only a landing bus write may change the sleep directions
    keep_dir_a: assert property (
        !(avs_write_i && !avs_waitrequest_o) |=> $stable(st_r.sleep_dir))
        else $error("sleep dir changed");

    // a full-word write to the sleep directions keeps the low 22 bits
    dir_write_a: assert property (
        avs_write_i && !avs_waitrequest_o && avs_byteenable_i == 4'hF
        && avs_address_i == spd_pkg::SLEEP_DIR_ADDR
        |=> st_r.sleep_dir == $past(avs_writedata_i[21:0]))
        else $error("sleep dir write lost");

    // the held copy is the register value seen just before sleep entry
    latch_a: assert property (
        sleep_req_i && st_r.mode == spd_pkg::SPD_RUN
        |=> st_r.latched == $past(st_r.sleep_dir))
        else $error("latch wrong");

    // held pins: zero bit drives low, one bit floats as input
    pin_drive_a: assert property (
        pin_hold_flag_o ##1 pin_hold_flag_o
        |=> pin_oe_n_o == $past(st_r.latched) && pin_out_o == 22'h000000)
        else $error("held pin wrong");

    // released pins follow their peripheral one cycle later
    free_pin_a: assert property (
        !pin_hold_flag_o
        |=> pin_out_o == $past(periph_out_i) && pin_oe_n_o == ~$past(periph_dir_i))
        else $error("free pin wrong");

    // the hold flag only falls through a landing bus write
    hold_keep_a: assert property (
        pin_hold_flag_o && !(avs_write_i && !avs_waitrequest_o) |=> pin_hold_flag_o)
        else $error("hold dropped");

    // sleep entry clears the release bit and holds the pins
    rel_clr_a: assert property (
        sleep_req_i && st_r.mode == spd_pkg::SPD_RUN
        |=> !st_r.release_bit && pin_hold_flag_o)
        else $error("release kept");

    // sleep entry restores non-inverted data on port 2
    pol_set_a: assert property (
        sleep_req_i && st_r.mode == spd_pkg::SPD_RUN
        |=> port2_tx_polarity_o && port2_rx_polarity_o)
        else $error("polarity");

    // reserved bits of the sleep directions always read zero
    resv_zero_a: assert property (
        !avs_waitrequest_o && avs_address_i == spd_pkg::SLEEP_DIR_ADDR
        |-> avs_readdata_o[31:22] == 10'h000 || avs_write_i)
        else $error("reserved bits nonzero");

    // every access gets exactly one wait state
    wait_one_a: assert property (
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("answer late");

    // the answer stands a single cycle, so a held request is not taken twice
    wait_rise_a: assert property (
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer stood too long");

    // the unused mode code is never reached
    mode_legal_a: assert property (
        st_r.mode inside {spd_pkg::SPD_RUN, spd_pkg::SPD_SLEEP, spd_pkg::SPD_HOLD})
        else $error("illegal mode");

    sleep_c: cover property (st_r.mode == spd_pkg::SPD_SLEEP);
    wake_c:  cover property (st_r.mode == spd_pkg::SPD_HOLD ##1 st_r.mode == spd_pkg::SPD_RUN);
    wr_c:    cover property (avs_write_i && !avs_waitrequest_o);
    rel_c:   cover property (st_r.release_bit);
    soft_c:  cover property (soft_reset_i ##1 periph_rst_o);
endmodule : spd_sleep_dir

//--- sim/test_sleep_pin_direction_register.sv
/* self-checking bench for the sleep pin direction block: bus tasks, resets, sleep and hold.
   assumes spd_sleep_dir alone on one 100 MHz clock, avalon-mm slave answering with waitrequest. */
`timescale 1ns/1ps
module test_sleep_pin_direction_register;
    logic        sys_clk_i;
    logic        sys_rst_i;
    logic        soft_reset_i;
    logic        sleep_req_i;
    logic        wake_i;
    logic [31:0] avs_address_i;
    logic        avs_read_i;
    logic        avs_write_i;
    logic [31:0] avs_writedata_i;
    logic [3:0]  avs_byteenable_i;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic [21:0] periph_out_i;
    logic [21:0] periph_dir_i;
    logic [21:0] pin_out_o;
    logic [21:0] pin_oe_n_o;
    logic        periph_rst_o;
    logic [21:0] normal_pin_direction_o;
    logic        port2_tx_polarity_o;
    logic        port2_rx_polarity_o;
    logic        pin_hold_flag_o;
    int          mismatches;
    int          tests_run;
    localparam logic [21:0] PAT = 22'h2A5C93; // mixed pattern for the sleep directions

    spd_sleep_dir spd_sleep_dir_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .soft_reset_i(soft_reset_i), .sleep_req_i(sleep_req_i), .wake_i(wake_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .periph_out_i(periph_out_i), .periph_dir_i(periph_dir_i), .pin_out_o(pin_out_o),
        .pin_oe_n_o(pin_oe_n_o), .periph_rst_o(periph_rst_o),
        .normal_pin_direction_o(normal_pin_direction_o),
        .port2_tx_polarity_o(port2_tx_polarity_o), .port2_rx_polarity_o(port2_rx_polarity_o),
        .pin_hold_flag_o(pin_hold_flag_o));

    ////////////////////////////////////////////////////////////////////////////////
    // clock at 100 MHz
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and run end, also reached when a wait runs out
    task automatic summarize();
        $display("compares %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t register read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_port(input logic [21:0] got, input logic [21:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t port value %h expected %h", $time, got, exp);
        end
    endtask : chk_port

    ////////////////////////////////////////////////////////////////////////////////
    // one bus cycle; request held until the edge that sees waitrequest low
    task automatic bus_op(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
                          output logic [31:0] data);
        int n;
        @(posedge sys_clk_i);
        avs_address_i   <= addr;
        avs_writedata_i <= wdata;
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk_i);
            if (avs_waitrequest_o === 1'b0) break;
        end
        data = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        if (n == 50) begin
            mismatches++;
            $display("[FAIL] %0t bus answer never came", $time);
            summarize();
        end
    endtask : bus_op

    task automatic wr(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] dummy;
        bus_op(1'b1, addr, data, dummy);
    endtask : wr

    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] got;
        bus_op(1'b0, addr, 32'h00000000, got);
        chk_reg(got, exp);
    endtask : rd_chk

    // one-cycle pulse on a control input, then look just after the edge that saw it
    // which: 0 soft reset, 1 sleep request, 2 wake
    task automatic pulse(input int which);
        @(posedge sys_clk_i);
        unique case (which)
            0: soft_reset_i <= 1'b1;
            1: sleep_req_i <= 1'b1;
            default: wake_i <= 1'b1;
        endcase
        @(posedge sys_clk_i);
        soft_reset_i <= 1'b0;
        sleep_req_i  <= 1'b0;
        wake_i       <= 1'b0;
        #1;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        mismatches = 0; tests_run = 0;
        sys_rst_i = 1'b1; soft_reset_i = 1'b0; sleep_req_i = 1'b0; wake_i = 1'b0;
        avs_address_i = 32'h00000000; avs_read_i = 1'b0; avs_write_i = 1'b0;
        avs_writedata_i = 32'h00000000; avs_byteenable_i = 4'hF;
        periph_out_i = 22'h3FFFFF; periph_dir_i = 22'h3FFFFF;
        repeat (12) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rd_chk(spd_pkg::SLEEP_DIR_ADDR, 32'h003FFFFF);
        chk_port(normal_pin_direction_o, 22'h000000);
        chk_port({19'h0, pin_hold_flag_o, port2_tx_polarity_o, port2_rx_polarity_o},
                 22'h000003);
        chk_port(pin_oe_n_o, 22'h000000);
        $display("test reset values done");
        // reserved bits and an unmapped place
        wr(spd_pkg::SLEEP_DIR_ADDR, 32'hFFEA5C93);
        rd_chk(spd_pkg::SLEEP_DIR_ADDR, {10'h000, PAT});
        avs_byteenable_i <= 4'h4;
        wr(spd_pkg::SLEEP_DIR_ADDR, 32'h00C00000);
        avs_byteenable_i <= 4'hF;
        rd_chk(spd_pkg::SLEEP_DIR_ADDR, 32'h00005C93);
        wr(spd_pkg::SLEEP_DIR_ADDR, {10'h000, PAT});
        wr(32'h90060100, 32'hFFFFFFFF);
        rd_chk(32'h90060100, spd_pkg::UNMAPPED_DATA);
        $display("test reserved bits done");
        // soft reset clears the normal directions only
        wr(spd_pkg::NORMAL_DIR_ADDR, 32'h003FFFFF);
        #1;
        chk_port(normal_pin_direction_o, 22'h3FFFFF);
        pulse(0);
        chk_port({21'h0, periph_rst_o}, 22'h000001);
        repeat (2) @(posedge sys_clk_i);
        chk_port(normal_pin_direction_o, 22'h000000);
        rd_chk(spd_pkg::SLEEP_DIR_ADDR, {10'h000, PAT});
        $display("test soft reset done");
        // polarities low before sleep so that sleep entry must raise them
        wr(spd_pkg::CTRL_ADDR, 32'h00000000);
        wr(spd_pkg::NORMAL_DIR_ADDR, 32'h00000F0F);
        pulse(1);
        chk_port({20'h0, pin_hold_flag_o, periph_rst_o}, 22'h000003);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk_port(pin_out_o, 22'h000000);
        chk_port(pin_oe_n_o, PAT);
        chk_port(normal_pin_direction_o, 22'h000000);
        chk_port({20'h0, port2_tx_polarity_o, port2_rx_polarity_o}, 22'h000003);
        rd_chk(spd_pkg::SLEEP_DIR_ADDR, {10'h000, PAT});
        rd_chk(spd_pkg::STATUS_ADDR, 32'h00000001);
        rd_chk(spd_pkg::CTRL_ADDR, 32'h0000000D);
        $display("test sleep entry done");
        // wake, rewrite, pins stay held until the flag is cleared
        pulse(2);
        periph_out_i <= 22'h155555;
        periph_dir_i <= 22'h0F0F0F;
        wr(spd_pkg::SLEEP_DIR_ADDR, 32'h003FFFFF);
        chk_port(pin_oe_n_o, PAT);
        chk_port(pin_out_o, 22'h000000);
        wr(spd_pkg::CTRL_ADDR, 32'h00000001);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk_port({21'h0, pin_hold_flag_o}, 22'h000000);
        chk_port(pin_out_o, 22'h155555);
        chk_port(pin_oe_n_o, ~22'h0F0F0F);
        $display("test wake and hold clear done");
        // second sleep released through the release bit
        pulse(1);
        pulse(2);
        chk_port({21'h0, pin_hold_flag_o}, 22'h000001);
        chk_port(pin_oe_n_o, 22'h3FFFFF);
        wr(spd_pkg::CTRL_ADDR, 32'h00000002);
        repeat (2) @(posedge sys_clk_i);
        #1;
        chk_port({21'h0, pin_hold_flag_o}, 22'h000000);
        $display("test release bit done");
        // hard reset in mid-run restores the sleep directions
        wr(spd_pkg::SLEEP_DIR_ADDR, {10'h000, PAT});
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rd_chk(spd_pkg::SLEEP_DIR_ADDR, 32'h003FFFFF);
        $display("test hard reset done");
        summarize();
    end
endmodule : test_sleep_pin_direction_register
